//--- core/drive_words_pkg.sv
// constants for the drive command and state words
package drive_words_pkg;
  localparam int unsigned word_w = 16;
  localparam logic [15:0] state_param_num = 16'h03c8;
  localparam logic [15:0] state_word_reset = 16'h0000;
  localparam logic [15:0] cmd_word_reset = 16'h0000;
  localparam int unsigned bit_fault_ack = 7;
  localparam int unsigned bit_jog_pos = 8;
  localparam int unsigned bit_jog_neg = 9;
  localparam int unsigned bit_plc_ctrl = 10;
  localparam int unsigned bit_homing = 11;
  localparam int unsigned bit_relative = 12;
  localparam int unsigned bit_change_now = 13;
  localparam int unsigned st_fault = 3;
  localparam int unsigned st_no_coast = 4;
  localparam int unsigned st_no_quick = 5;
  localparam int unsigned st_warning = 7;
  localparam int unsigned st_in_tol = 8;
  localparam int unsigned st_ctrl_req = 9;
  localparam int unsigned st_target = 10;
  localparam int unsigned st_home_set = 11;
  localparam int unsigned st_task_ack = 12;
  localparam int unsigned st_stopped = 13;
  localparam int unsigned num_faults = 8;
  typedef enum logic [1:0] {pos_idle, pos_run, pos_run_queued} pos_state_t;
endpackage

//--- core/edge_detect.sv
// rising and falling edge detector for one command bit
`timescale 1ns/10ps
`default_nettype none
module edge_detect (
  input wire logic clk,
  input wire logic rst,
  input wire logic level,
  output logic rise,
  output logic fall
);
  logic last_reg;
  logic last_next;

  always_comb begin
    last_next = level;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      last_reg <= 1'b0;
    end else begin
      last_reg <= last_next;
    end
  end

  assign rise = level & ~last_reg;
  assign fall = ~level & last_reg;
endmodule
`default_nettype wire

//--- core/drive_control_status_words.sv
// command word decode and state word assembly for the servo drive
// Notes on behaviour
// R1: fault acknowledge clears only faults whose cause cleared
// R2: positive jog starts on rise, decelerates on fall
// R3: negative jog starts on rise, decelerates on fall
// R4: plc control bit low ignores the command word
// R5: homing starts on rise, fall cancels without error
// R6: homing uses stored options, not command bits
// R7: change bit zero queues the new positioning
// R8: change bit one aborts and starts at once
// R9: 16-bit state word, parameter 968, resets zero
// R10: bits 0,1,2,6 carry one state code jointly
// R11: bit 4 set while no coast stop
// R12: bit 5 set while no quick stop
// R13: bit 8 following or speed error in tolerance
// R14: bit 10 target reached or speed threshold
// R15: relative bit sampled at each positioning start
// R16: fault, warning, home, ack, stopped placed; 14-15 zero
// R17: bit 9 mirrors command bit 10
// R18: task ack clear when new job accepted; code sets it while a job is queued or homing is active
// R19: stopped when speed zero and idle or halted
`timescale 1ns/10ps
`default_nettype none
module drive_control_status_words #(
  parameter int unsigned faults = drive_words_pkg::num_faults
) (
  input wire logic clk,
  input wire logic rst,
  // command word from the cyclic controller, same clock domain
  input wire logic [15:0] cmd_word,
  input wire logic cmd_write,
  output logic [15:0] cmd_word_rd,
  output logic [15:0] state_word,
  output logic [15:0] state_param_num,
  // drive side status inputs
  input wire logic [3:0] drive_state_code,
  input wire logic coast_stop_cmd,
  input wire logic quick_stop_cmd,
  input wire logic [faults-1:0] fault_event,
  input wire logic [faults-1:0] fault_cause,
  input wire logic warning,
  input wire logic position_mode,
  input wire logic following_in_tol,
  input wire logic speed_in_tol,
  input wire logic target_reached,
  input wire logic speed_over_thresh,
  input wire logic home_valid,
  input wire logic speed_zero,
  input wire logic halt_active,
  input wire logic pos_start,
  input wire logic pos_done,
  input wire logic homing_done,
  input wire logic [1:0] stored_homing_opts,
  // motion requests toward the motion controller
  output logic [faults-1:0] fault_pending,
  output logic jog_set_positive,
  output logic jog_set_negative,
  output logic jog_decel,
  output logic homing_active,
  output logic homing_start,
  output logic homing_cancel,
  output logic [1:0] homing_opts,
  output logic pos_launch,
  output logic pos_abort,
  output logic pos_relative,
  output logic pos_queued
);
  // ******************************
  // command register and edges
  // ******************************
  logic [15:0] cmd_reg, cmd_next;
  logic plc_en;
  logic ack_rise, jp_rise, jp_fall, jn_rise, jn_fall, hm_rise, hm_fall;

  always_comb begin
    cmd_next = cmd_write ? cmd_word : cmd_reg;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_reg <= drive_words_pkg::cmd_word_reset;
    end else begin
      cmd_reg <= cmd_next;
    end
  end
  assign cmd_word_rd = cmd_reg;
  assign state_param_num = drive_words_pkg::state_param_num; // R9
  // gating the bits, not the edges, makes a bit already held fire a rise once control is given
  assign plc_en = cmd_reg[drive_words_pkg::bit_plc_ctrl]; // R4

  edge_detect u_ack (.clk(clk), .rst(rst),
    .level(plc_en & cmd_reg[drive_words_pkg::bit_fault_ack]),
    .rise(ack_rise), .fall());
  edge_detect u_jp (.clk(clk), .rst(rst),
    .level(plc_en & cmd_reg[drive_words_pkg::bit_jog_pos]),
    .rise(jp_rise), .fall(jp_fall));
  edge_detect u_jn (.clk(clk), .rst(rst),
    .level(plc_en & cmd_reg[drive_words_pkg::bit_jog_neg]),
    .rise(jn_rise), .fall(jn_fall));
  edge_detect u_hm (.clk(clk), .rst(rst),
    .level(plc_en & cmd_reg[drive_words_pkg::bit_homing]),
    .rise(hm_rise), .fall(hm_fall));

  // ******************************
  // faults
  // ******************************
  logic [faults-1:0] fault_reg, fault_next;
  always_comb begin
    fault_next = fault_reg;
    if (ack_rise) begin
      fault_next = fault_reg & fault_cause; // R1
    end
    fault_next = fault_next | fault_event;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_reg <= '0;
    end else begin
      fault_reg <= fault_next;
    end
  end
  assign fault_pending = fault_reg;

  // ******************************
  // jog and homing
  // ******************************
  logic jp_reg, jp_next, jn_reg, jn_next, hm_reg, hm_next, dec_reg, dec_next;
  always_comb begin
    jp_next = jp_reg;
    jn_next = jn_reg;
    dec_next = 1'b0;
    hm_next = hm_reg;
    if (jp_rise) jp_next = 1'b1; // R2
    if (jp_fall) begin
      jp_next = 1'b0; // R2
      dec_next = jp_reg;
    end
    if (jn_rise) jn_next = 1'b1; // R3
    if (jn_fall) begin
      jn_next = 1'b0; // R3
      dec_next = dec_next | jn_reg;
    end
    if (hm_rise) hm_next = 1'b1; // R5
    else if (hm_fall || homing_done) hm_next = 1'b0; // R5
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      jp_reg <= 1'b0;
      jn_reg <= 1'b0;
      dec_reg <= 1'b0;
      hm_reg <= 1'b0;
    end else begin
      jp_reg <= jp_next;
      jn_reg <= jn_next;
      dec_reg <= dec_next;
      hm_reg <= hm_next;
    end
  end
  assign jog_set_positive = jp_reg;
  assign jog_set_negative = jn_reg;
  assign jog_decel = dec_reg;
  assign homing_active = hm_reg;
  assign homing_start = hm_rise;
  assign homing_cancel = hm_fall & hm_reg; // R5
  assign homing_opts = stored_homing_opts; // R6

  // ******************************
  // positioning sequencer
  // ******************************
  drive_words_pkg::pos_state_t pst_reg, pst_next;
  logic rel_reg, rel_next, launch_reg, launch_next, abort_reg, abort_next;
  logic start_ok, chg;
  assign start_ok = position_mode & plc_en & pos_start & ~hm_reg;
  assign chg = cmd_reg[drive_words_pkg::bit_change_now];
  always_comb begin
    pst_next = pst_reg;
    rel_next = rel_reg;
    launch_next = 1'b0;
    abort_next = 1'b0;
    case (pst_reg)
      drive_words_pkg::pos_idle: begin
        if (start_ok) begin
          pst_next = drive_words_pkg::pos_run;
          launch_next = 1'b1;
          rel_next = cmd_reg[drive_words_pkg::bit_relative]; // R15
        end
      end
      drive_words_pkg::pos_run: begin
        if (start_ok && chg) begin
          abort_next = 1'b1; // R8
          launch_next = 1'b1; // R8
          rel_next = cmd_reg[drive_words_pkg::bit_relative]; // R15
        end else if (start_ok) begin
          pst_next = drive_words_pkg::pos_run_queued; // R7
          rel_next = cmd_reg[drive_words_pkg::bit_relative]; // R15
        end else if (pos_done) begin
          pst_next = drive_words_pkg::pos_idle;
        end
      end
      drive_words_pkg::pos_run_queued: begin
        if (start_ok && chg) begin
          pst_next = drive_words_pkg::pos_run;
          abort_next = 1'b1; // R8
          launch_next = 1'b1;
          rel_next = cmd_reg[drive_words_pkg::bit_relative];
        end else if (pos_done) begin
          pst_next = drive_words_pkg::pos_run;
          launch_next = 1'b1; // R7
        end
      end
      default: pst_next = drive_words_pkg::pos_idle;
    endcase
    if (!position_mode) begin
      pst_next = drive_words_pkg::pos_idle;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      pst_reg <= drive_words_pkg::pos_idle;
      rel_reg <= 1'b0;
      launch_reg <= 1'b0;
      abort_reg <= 1'b0;
    end else begin
      pst_reg <= pst_next;
      rel_reg <= rel_next;
      launch_reg <= launch_next;
      abort_reg <= abort_next;
    end
  end
  assign pos_launch = launch_reg;
  assign pos_abort = abort_reg;
  assign pos_relative = rel_reg;
  assign pos_queued = (pst_reg == drive_words_pkg::pos_run_queued);

  // ******************************
  // state word
  // ******************************
  logic [15:0] st_reg, st_next;
  logic pos_busy;
  // busy in both run states: a running job counts as busy as well as a queued one
  assign pos_busy = (pst_reg != drive_words_pkg::pos_idle);
  always_comb begin
    st_next = '0; // R16
    st_next[2:0] = drive_state_code[2:0]; // R10
    st_next[6] = drive_state_code[3]; // R10
    st_next[drive_words_pkg::st_fault] = |fault_reg; // R16
    st_next[drive_words_pkg::st_no_coast] = ~coast_stop_cmd; // R11
    st_next[drive_words_pkg::st_no_quick] = ~quick_stop_cmd; // R12
    st_next[drive_words_pkg::st_warning] = warning; // R16
    st_next[drive_words_pkg::st_in_tol] =
      position_mode ? following_in_tol : speed_in_tol; // R13
    st_next[drive_words_pkg::st_ctrl_req] = plc_en; // R17
    st_next[drive_words_pkg::st_target] =
      position_mode ? target_reached : speed_over_thresh; // R14
    st_next[drive_words_pkg::st_home_set] = home_valid; // R16
    st_next[drive_words_pkg::st_task_ack] =
      (pst_reg == drive_words_pkg::pos_run_queued) | hm_reg; // R18
    st_next[drive_words_pkg::st_stopped] =
      speed_zero & (~pos_busy | halt_active); // R19
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= drive_words_pkg::state_word_reset; // R9
    end else begin
      st_reg <= st_next;
    end
  end
  assign state_word = st_reg;

  // ******************************
  // checks
  // ******************************
  ctrl_mirror_a: assert property (@(posedge clk) disable iff (rst) // R17
    ##1 st_reg[9] == $past(cmd_reg[10]))
    else $error("control requested does not mirror command bit");
  coast_bit_a: assert property (@(posedge clk) disable iff (rst) // R11
    coast_stop_cmd |=> !st_reg[4]) else $error("coast bit wrong");
  quick_bit_a: assert property (@(posedge clk) disable iff (rst) // R12
    !quick_stop_cmd |=> st_reg[5]) else $error("quick bit wrong");
  reserved_zero_a: assert property (@(posedge clk) disable iff (rst) // R16
    st_reg[15:14] == 2'b00) else $error("reserved bits set");
  ack_keep_a: assert property (@(posedge clk) disable iff (rst) // R1
    (fault_reg & fault_cause) != '0 |=>
    (fault_reg & $past(fault_reg & fault_cause)) ==
    $past(fault_reg & fault_cause))
    else $error("live fault cleared");
  ignore_cmd_a: assert property (@(posedge clk) disable iff (rst) // R4
    !plc_en && !jp_reg |=> !jp_reg) else $error("jog without control");
  jog_start_a: assert property (@(posedge clk) disable iff (rst) // R2
    jp_rise |=> jog_set_positive) else $error("jog did not start");
  jog_neg_a: assert property (@(posedge clk) disable iff (rst) // R3
    jn_fall && jn_reg |=> jog_decel && !jog_set_negative)
    else $error("negative jog did not decelerate");
  home_cancel_a: assert property (@(posedge clk) disable iff (rst) // R5
    homing_cancel |=> !homing_active) else $error("homing not cancelled");
  queue_pos_a: assert property (@(posedge clk) disable iff (rst) // R7
    pst_reg == drive_words_pkg::pos_run && start_ok && !chg
    |=> pos_queued && !pos_abort) else $error("job not queued");
  abort_pos_a: assert property (@(posedge clk) disable iff (rst) // R8
    pst_reg != drive_words_pkg::pos_idle && start_ok && chg
    |=> pos_abort && pos_launch) else $error("job not replaced");
  stop_flag_a: assert property (@(posedge clk) disable iff (rst) // R19
    speed_zero && !pos_busy |=> st_reg[13]) else $error("stopped missing");
  jog_cov: cover property (@(posedge clk) jp_rise ##[1:20] jp_fall);
  queue_cov: cover property (@(posedge clk) pos_queued ##[1:50] pos_launch);
  abort_cov: cover property (@(posedge clk) pos_abort);
endmodule
`default_nettype wire

//--- test/plc_model.sv
// cyclic controller model: writes the command word, reads the state word
`timescale 1ns/10ps
`default_nettype none
module plc_model (
  input wire logic clk,
  input wire logic [15:0] state_word,
  output logic [15:0] cmd_word,
  output logic cmd_write,
  output logic [3:0] state_code
);
  // ***************
  // word exchange
  // ***************
  // the drive state is only meaningful as one field, never bit by bit
  assign state_code = {state_word[6], state_word[2:0]};
  initial begin
    cmd_word = 16'h0000;
    cmd_write = 1'b0;
  end
  // reserved bits go out as zero; the bus shows junk once released
  task automatic send(input logic [15:0] w);
    @(posedge clk);
    cmd_word <= w & 16'h3fff;
    cmd_write <= 1'b1;
    @(posedge clk);
    cmd_write <= 1'b0;
    cmd_word <= ~w;
  endtask
endmodule
`default_nettype wire

//--- test/test_drive_control_status_words.sv
// self-checking bench for the command and state words
`timescale 1ns/10ps
`default_nettype none
module test_drive_control_status_words;
  // ***************
  // harness
  // ***************
  typedef struct {int sel; logic [15:0] v;} note_t;
  logic clk, rst, cw_wr, hd;
  logic [15:0] cw, sw, psn, st_in, r, cw_rd;
  logic [7:0] fe, fc, fp;
  logic [1:0] pp, hopts, ho;
  logic [3:0] code;
  logic jp, jn, jd, ha, hs, hc, pl, pa, pr, pq;
  logic [15:0] obs [0:15];
  string nm [0:15] = '{"state", "jog_pos", "jog_neg", "decel", "h_start",
    "h_act", "h_opts", "h_cancel", "launch", "abort", "relative",
    "queued", "faults", "param", "code", "cmd_rd"};
  note_t q[$];
  note_t n;
  int fails = 0;
  int samples_checked = 0;
  int i;
  always_comb obs = '{sw, 16'(jp), 16'(jn), 16'(jd), 16'(hs), 16'(ha),
    16'(ho), 16'(hc), 16'(pl), 16'(pa), 16'(pr), 16'(pq), 16'(fp), psn,
    16'(code), cw_rd};
  plc_model plc (.clk(clk), .state_word(sw), .cmd_word(cw),
    .cmd_write(cw_wr), .state_code(code));
  drive_control_status_words DUT (.clk(clk), .rst(rst), .cmd_word(cw),
    .cmd_write(cw_wr), .cmd_word_rd(cw_rd), .state_word(sw),
    .state_param_num(psn), .drive_state_code(st_in[3:0]),
    .coast_stop_cmd(st_in[4]), .quick_stop_cmd(st_in[5]),
    .fault_event(fe), .fault_cause(fc), .warning(st_in[6]),
    .position_mode(st_in[7]), .following_in_tol(st_in[8]),
    .speed_in_tol(st_in[9]), .target_reached(st_in[10]),
    .speed_over_thresh(st_in[11]), .home_valid(st_in[12]),
    .speed_zero(st_in[13]), .halt_active(st_in[14]), .pos_start(pp[0]),
    .pos_done(pp[1]), .homing_done(hd), .stored_homing_opts(hopts),
    .fault_pending(fp), .jog_set_positive(jp), .jog_set_negative(jn),
    .jog_decel(jd), .homing_active(ha), .homing_start(hs),
    .homing_cancel(hc), .homing_opts(ho), .pos_launch(pl), .pos_abort(pa),
    .pos_relative(pr), .pos_queued(pq));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic expect_val(int sel, logic [15:0] v);
    q.push_back('{sel, v});
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic pulse(int b);
    @(posedge clk);
    pp <= 2'b01 << b;
    @(posedge clk);
    pp <= 2'b00;
  endtask
  // b: a job runs under plc control, so stopped also needs a halt
  function automatic logic [15:0] exp_state(logic [15:0] s, logic b);
    return {2'b00, s[13] & (~b | s[14]), 1'b0, s[12],
      s[7] ? s[10] : s[11], b,
      s[7] ? s[8] : s[9], s[6], s[3], ~s[5], ~s[4], 1'b0, s[2:0]};
  endfunction
  // pulses are only valid in their own cycle, so drain every note at once
  always @(negedge clk) begin
    while (q.size() > 0) begin
      n = q.pop_front();
      samples_checked++;
      if (obs[n.sel] !== n.v) begin
        fails++;
        $display("BAD %s exp %h got %h", nm[n.sel], n.v, obs[n.sel]);
      end
    end
  end
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    end_sim();
  end
  // ***************
  // tests
  // ***************
  initial begin
    void'($urandom(57707));
    rst = 1'b1;
    st_in = 16'h0000;
    fe = 8'h00;
    fc = 8'h00;
    pp = 2'b00;
    hd = 1'b0;
    hopts = 2'b10;
    tick(12);
    expect_val(0, 16'h0000);
    expect_val(13, 16'h03c8);
    rst <= 1'b0;
    for (i = 0; i < 24; i++) begin
      r = 16'($urandom());
      @(posedge clk);
      st_in <= r;
      @(posedge clk);
      expect_val(0, exp_state(r, 1'b0));
      expect_val(14, 16'(r[3:0]));
    end
    $display("status test done");
    st_in <= 16'h0000;
    plc.send(16'h0100);
    tick(2);
    expect_val(1, 16'h0000);
    plc.send(16'h0500);
    tick(2);
    expect_val(1, 16'h0001);
    expect_val(0, 16'h0230);
    expect_val(15, 16'h0500);
    plc.send(16'h0400);
    tick(1);
    expect_val(1, 16'h0000);
    expect_val(3, 16'h0001);
    plc.send(16'h0600);
    tick(2);
    expect_val(2, 16'h0001);
    plc.send(16'h0200);
    tick(1);
    expect_val(2, 16'h0000);
    expect_val(3, 16'h0001);
    $display("jog test done");
    r = 16'($urandom());
    hopts <= r[1:0];
    // the start and cancel pulses stand only in the cycle after storage
    plc.send(16'h0c00);
    expect_val(4, 16'h0001);
    tick(1);
    expect_val(5, 16'h0001);
    expect_val(6, 16'(r[1:0]));
    tick(1);
    expect_val(0, 16'h1230);
    plc.send(16'h0400);
    expect_val(7, 16'h0001);
    tick(1);
    expect_val(5, 16'h0000);
    expect_val(12, 16'h0000);
    plc.send(16'h0c00);
    tick(1);
    hd <= 1'b1;
    tick(1);
    hd <= 1'b0;
    expect_val(5, 16'h0000);
    $display("homing test done");
    st_in <= 16'h0080;
    plc.send(16'h1400);
    pulse(0);
    expect_val(8, 16'h0001);
    expect_val(10, 16'h0001);
    plc.send(16'h0400);
    pulse(0);
    expect_val(11, 16'h0001);
    expect_val(8, 16'h0000);
    pulse(1);
    expect_val(8, 16'h0001);
    expect_val(11, 16'h0000);
    expect_val(0, 16'h1230);
    plc.send(16'h2400);
    pulse(0);
    expect_val(9, 16'h0001);
    expect_val(8, 16'h0001);
    expect_val(10, 16'h0000);
    // job still running: stopped needs zero speed and a halt
    for (i = 0; i < 8; i++) begin
      r = (16'($urandom()) & 16'h7f7f) | 16'h0080;
      @(posedge clk);
      st_in <= r;
      @(posedge clk);
      expect_val(0, exp_state(r, 1'b1));
    end
    $display("positioning test done");
    @(posedge clk);
    fe <= 8'h03;
    fc <= 8'h02;
    @(posedge clk);
    fe <= 8'h00;
    tick(1);
    expect_val(12, 16'h0003);
    plc.send(16'h0480);
    tick(3);
    expect_val(12, 16'h0002);
    $display("fault test done");
    tick(2);
    end_sim();
  end
endmodule
`default_nettype wire
